/* hdl/dc_ctl_regs.svh */
`ifndef DC_CTL_REGS_SVH
`define DC_CTL_REGS_SVH
// ****************************************
// register offsets
// ****************************************
`define OFS_BW_LO 12'h930
`define OFS_BW_HI 12'h931
`define OFS_DEV_LO 12'h932
`define OFS_DEV_HI 12'h933
`define OFS_TD_DEPTH 12'h934
`define OFS_SP_DEPTH 12'h935
`define OFS_CYC_OWN 12'h980
`define OFS_SYNC_ACT 12'h981
`define OFS_START0 12'h990
`define OFS_START_LO_END 12'h993
`define OFS_START_HI_END 12'h997
// ****************************************
// fields and reset values
// ****************************************
`define BW_RST 16'h1000
`define BW_LIMIT_SUB 17'h0007f
`define DEPTH_RST 4'h0
`define CYC_OWN_RST 8'h00
`define CYC_OWN_MASK 8'h31
`define ACT_RST 8'h00
`define ACT_STORE_MASK 8'h7f
`define ACT_UNIT 0
`define ACT_EN0 1
`define ACT_EN1 2
`define ACT_AUTO 3
`define ACT_EXT 4
`define ACT_CHECK 5
`define ACT_NEAR 6
`define ACT_DEBUG 7
`define OWN_SYNC 0
`define OWN_LATCH0 4
`define OWN_LATCH1 5
// ****************************************
// near-future windows in ns
// ****************************************
`define NEAR_WIDE_NS 64'h8000_0000_0000_0000
`define NEAR_SHORT_NS 64'h0000_0000_8000_0000
`endif

/* hdl/dc_ctl_pkg.sv */
package dc_ctl_pkg;
   // side that owns a unit
   typedef enum logic {SIDE_NET, SIDE_HOST} side_t;
   typedef logic [7:0] byte_t;
endpackage

/* hdl/dc_time_loop_sync_ctl.sv */
`timescale 1ns/1ps
`include "dc_ctl_regs.svh"
// Behaviour
// - low fifteen bits of bandwidth register set the time-copy adjustment bandwidth.
// - any bandwidth write clears time difference and speed deviation.
// - deviation readout is 16-bit two's complement, bounded by bandwidth minus 0x7f.
// - time difference filter depth is 4 bits; a write clears time difference.
// - speed filter depth is 4 bits; a write resets speed counter filter.
// - loop registers writable from network; host only when host controls system time.
// - ownership bit 0 picks sync unit owner; only network writes this register.
// - ownership bit 4 picks latch 0 owner; forced host when host controls time.
// - ownership bit 5 picks latch 1 owner; latch interrupts go to owner.
// - activation bit 0 turns sync unit on; whole register resets to zero.
// - activation bits 1 and 2 enable first and second sync outputs.
// - with bit 3 set, writing start time sets the activation bit.
// - with bit 4 set, a 32-bit start time is extended to 64 bits.
// - bit 5 clear waits for start time; set fires at once if outside window.
// - bit 6 picks near window: half counter width, or about 2.1 seconds.
// - writing bit 7 emits one debug pulse on enabled outputs; reads zero.
// - activation register accepts writes only from the sync unit owner.
// - start time register holds system time in ns where cyclic operation begins.
module dc_time_loop_sync_ctl
   import dc_ctl_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST_N,
   // network side register port
   input wire logic [11:0] NET_ADDR,
   input wire logic [7:0] NET_WDATA,
   input wire logic NET_WR,
   input wire logic NET_RD,
   output logic [7:0] NET_RDATA,
   // host side register port
   input wire logic [11:0] HOST_ADDR,
   input wire logic [7:0] HOST_WDATA,
   input wire logic HOST_WR,
   input wire logic HOST_RD,
   output logic [7:0] HOST_RDATA,
   // time loop
   input wire logic SYS_TIME_HOST_CTL,
   input wire logic [63:0] SYS_TIME,
   input wire logic [15:0] SPEED_DEV_IN,
   output logic [14:0] BANDWIDTH,
   output logic [3:0] TDIFF_DEPTH,
   output logic [3:0] SPEED_DEPTH,
   output logic TDIFF_CLR,
   output logic SPEED_DIFF_CLR,
   output logic SPEED_FILT_CLR,
   // ownership and latch interrupt routing
   output logic SYNC_OWNER_HOST,
   output logic LATCH0_OWNER_HOST,
   output logic LATCH1_OWNER_HOST,
   input wire logic [1:0] LATCH_IRQ,
   output logic [1:0] LATCH_IRQ_NET,
   output logic [1:0] LATCH_IRQ_HOST,
   // sync output unit
   output logic SYNC_UNIT_ACTIVE,
   output logic [63:0] START_TIME,
   output logic FIRST_SYNC_PULSE,
   output logic SECOND_SYNC_PULSE
);
   // ****************************************
   // helpers
   // ****************************************
   // byte write hit on one offset
   function automatic logic hit(input logic wr, input logic [11:0] a, input logic [11:0] ofs);
      hit = wr && (a == ofs);
   endfunction

   // clamp deviation to +/-(bandwidth - 0x7f)
   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [14:0] bw);
      logic signed [16:0] lim;
      logic signed [16:0] sv;
      lim = $signed({2'b00, bw} - `BW_LIMIT_SUB);
      sv = $signed({v[15], v});
      if (sv > lim) begin
         clamp = lim[15:0];
      end else if (sv < -lim) begin
         clamp = 16'((-lim));
      end else begin
         clamp = v;
      end
   endfunction

   // ****************************************
   // state
   // ****************************************
   logic [15:0] bw_r, bw_nxt;
   logic [15:0] dev_r, dev_nxt;
   logic [3:0] tdd_r, tdd_nxt;
   logic [3:0] spd_r, spd_nxt;
   logic [7:0] own_r, own_nxt;
   logic [7:0] act_r, act_nxt;
   logic [63:0] start_r, start_nxt;
   logic pend_r, pend_nxt;
   logic tclr_r, tclr_nxt, dclr_r, dclr_nxt, fclr_r, fclr_nxt;
   logic p0_r, p0_nxt, p1_r, p1_nxt;
   logic [7:0] nrd_r, nrd_nxt, hrd_r, hrd_nxt;
   side_t sync_owner;
   logic host_loop_ok, own_wr, outside, fire, dbg, start_done;
   logic [11:0] own_addr;
   logic [7:0] own_data;
   logic [63:0] ahead;
   // ****************************************
   // owner selection and plausibility
   // ****************************************
   always_comb begin
      sync_owner = own_r[`OWN_SYNC] ? SIDE_HOST : SIDE_NET;
      host_loop_ok = HOST_WR && SYS_TIME_HOST_CTL;
      // only the owner reaches activation and start time
      own_wr = (sync_owner == SIDE_HOST) ? HOST_WR : NET_WR;
      own_addr = (sync_owner == SIDE_HOST) ? HOST_ADDR : NET_ADDR;
      own_data = (sync_owner == SIDE_HOST) ? HOST_WDATA : NET_WDATA;
      ahead = start_r - SYS_TIME;
      // window choice
      outside = ahead >= (act_r[`ACT_NEAR] ? `NEAR_SHORT_NS : `NEAR_WIDE_NS);
      // reached, or early fire on implausible start
      fire = pend_r && (ahead[63] || ahead == 64'h0 || (act_r[`ACT_CHECK] && outside));
      dbg = hit(own_wr, own_addr, `OFS_SYNC_ACT) && own_data[`ACT_DEBUG];
      start_done = !act_r[`ACT_UNIT] && (hit(own_wr, own_addr, `OFS_START_HI_END) ||
         (act_r[`ACT_EXT] && hit(own_wr, own_addr, `OFS_START_LO_END)));
   end

   // ****************************************
   // register next values
   // ****************************************
   always_comb begin
      bw_nxt = bw_r;
      tdd_nxt = tdd_r;
      spd_nxt = spd_r;
      own_nxt = own_r;
      act_nxt = act_r;
      start_nxt = start_r;
      tclr_nxt = 1'b0;
      dclr_nxt = 1'b0;
      fclr_nxt = 1'b0;
      // host writes to loop registers first; network overrides
      if (hit(host_loop_ok, HOST_ADDR, `OFS_BW_LO)) begin
         bw_nxt[7:0] = HOST_WDATA;
      end
      if (hit(host_loop_ok, HOST_ADDR, `OFS_BW_HI)) begin
         bw_nxt[14:8] = HOST_WDATA[6:0];
      end
      if (hit(host_loop_ok, HOST_ADDR, `OFS_TD_DEPTH)) begin
         tdd_nxt = HOST_WDATA[3:0];
      end
      if (hit(host_loop_ok, HOST_ADDR, `OFS_SP_DEPTH)) begin
         spd_nxt = HOST_WDATA[3:0];
      end
      if (hit(NET_WR, NET_ADDR, `OFS_BW_LO)) begin
         bw_nxt[7:0] = NET_WDATA;
      end
      if (hit(NET_WR, NET_ADDR, `OFS_BW_HI)) begin
         bw_nxt[15:8] = NET_WDATA;
      end
      if (hit(NET_WR, NET_ADDR, `OFS_TD_DEPTH)) begin
         tdd_nxt = NET_WDATA[3:0];
      end
      if (hit(NET_WR, NET_ADDR, `OFS_SP_DEPTH)) begin
         spd_nxt = NET_WDATA[3:0];
      end
      // side effects of loop writes
      if (hit(NET_WR, NET_ADDR, `OFS_BW_LO) || hit(NET_WR, NET_ADDR, `OFS_BW_HI) ||
          hit(host_loop_ok, HOST_ADDR, `OFS_BW_LO) || hit(host_loop_ok, HOST_ADDR, `OFS_BW_HI)) begin
         tclr_nxt = 1'b1;
         dclr_nxt = 1'b1;
      end
      if (hit(NET_WR, NET_ADDR, `OFS_TD_DEPTH) || hit(host_loop_ok, HOST_ADDR, `OFS_TD_DEPTH)) begin
         tclr_nxt = 1'b1;
      end
      if (hit(NET_WR, NET_ADDR, `OFS_SP_DEPTH) || hit(host_loop_ok, HOST_ADDR, `OFS_SP_DEPTH)) begin
         fclr_nxt = 1'b1;
      end
      // ownership, network only
      if (hit(NET_WR, NET_ADDR, `OFS_CYC_OWN)) begin
         own_nxt = NET_WDATA & `CYC_OWN_MASK;
      end
      if (SYS_TIME_HOST_CTL) begin
         own_nxt[`OWN_LATCH0] = 1'b1;
      end
      // activation, bit 7 never stored
      if (hit(own_wr, own_addr, `OFS_SYNC_ACT)) begin
         act_nxt = own_data & `ACT_STORE_MASK;
      end
      // start time bytes, locked while active
      for (int i = 0; i < 8; i++) begin
         if (!act_r[`ACT_UNIT] && hit(own_wr, own_addr, 12'(`OFS_START0 + i))) begin
            start_nxt[i*8 +: 8] = own_data;
         end
      end
      // 32-bit write extended to the next future 64-bit time
      if (!act_r[`ACT_UNIT] && act_r[`ACT_EXT] && hit(own_wr, own_addr, `OFS_START_LO_END)) begin
         start_nxt[63:32] = ({own_data, start_r[23:0]} < SYS_TIME[31:0]) ?
            SYS_TIME[63:32] + 32'h1 : SYS_TIME[63:32];
      end
      if (start_done && act_r[`ACT_AUTO]) begin
         act_nxt[`ACT_UNIT] = 1'b1;
      end
   end

   // ****************************************
   // pulse generation next values
   // ****************************************
   always_comb begin
      pend_nxt = pend_r;
      if (!act_r[`ACT_UNIT]) begin
         pend_nxt = 1'b1; // armed until first pulse
      end else if (fire) begin
         pend_nxt = 1'b0;
      end
      // enables gate both start and debug pulses
      p0_nxt = ((act_r[`ACT_UNIT] && fire) || dbg) && act_r[`ACT_EN0];
      p1_nxt = ((act_r[`ACT_UNIT] && fire) || dbg) && act_r[`ACT_EN1];
      // clamped deviation readout
      dev_nxt = clamp(SPEED_DEV_IN, bw_r[14:0]);
      if (dclr_nxt) begin
         dev_nxt = 16'h0000;
      end
   end

   // ****************************************
   // read data
   // ****************************************
   function automatic logic [7:0] rd(input logic [11:0] a);
      case (a)
         `OFS_BW_LO: rd = bw_r[7:0];
         `OFS_BW_HI: rd = bw_r[15:8];
         `OFS_DEV_LO: rd = dev_r[7:0];
         `OFS_DEV_HI: rd = dev_r[15:8];
         `OFS_TD_DEPTH: rd = {4'h0, tdd_r};
         `OFS_SP_DEPTH: rd = {4'h0, spd_r};
         `OFS_CYC_OWN: rd = own_r;
         `OFS_SYNC_ACT: rd = act_r; // bit 7 reads zero
         default: rd = 8'h00;
      endcase
   endfunction

   always_comb begin
      nrd_nxt = NET_RD ? rd(NET_ADDR) : nrd_r;
      hrd_nxt = HOST_RD ? rd(HOST_ADDR) : hrd_r;
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         bw_r <= `BW_RST;
         dev_r <= 16'h0000;
         tdd_r <= `DEPTH_RST;
         spd_r <= `DEPTH_RST;
         own_r <= `CYC_OWN_RST;
         act_r <= `ACT_RST;
         start_r <= 64'h0;
         pend_r <= 1'b1;
         tclr_r <= 1'b0;
         dclr_r <= 1'b0;
         fclr_r <= 1'b0;
         p0_r <= 1'b0;
         p1_r <= 1'b0;
         nrd_r <= 8'h00;
         hrd_r <= 8'h00;
      end else begin
         bw_r <= bw_nxt;
         dev_r <= dev_nxt;
         tdd_r <= tdd_nxt;
         spd_r <= spd_nxt;
         own_r <= own_nxt;
         act_r <= act_nxt;
         start_r <= start_nxt;
         pend_r <= pend_nxt;
         tclr_r <= tclr_nxt;
         dclr_r <= dclr_nxt;
         fclr_r <= fclr_nxt;
         p0_r <= p0_nxt;
         p1_r <= p1_nxt;
         nrd_r <= nrd_nxt;
         hrd_r <= hrd_nxt;
      end
   end
   // ****************************************
   // outputs
   // ****************************************
   assign NET_RDATA = nrd_r;
   assign HOST_RDATA = hrd_r;
   assign BANDWIDTH = bw_r[14:0];
   assign TDIFF_DEPTH = tdd_r;
   assign SPEED_DEPTH = spd_r;
   assign TDIFF_CLR = tclr_r;
   assign SPEED_DIFF_CLR = dclr_r;
   assign SPEED_FILT_CLR = fclr_r;
   assign SYNC_OWNER_HOST = own_r[`OWN_SYNC];
   assign LATCH0_OWNER_HOST = own_r[`OWN_LATCH0];
   assign LATCH1_OWNER_HOST = own_r[`OWN_LATCH1];
   // interrupt to the owning side
   assign LATCH_IRQ_HOST = LATCH_IRQ & {own_r[`OWN_LATCH1], own_r[`OWN_LATCH0]};
   assign LATCH_IRQ_NET = LATCH_IRQ & ~{own_r[`OWN_LATCH1], own_r[`OWN_LATCH0]};
   assign SYNC_UNIT_ACTIVE = act_r[`ACT_UNIT];
   assign START_TIME = start_r;
   assign FIRST_SYNC_PULSE = p0_r;
   assign SECOND_SYNC_PULSE = p1_r;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   a_bw_write_clears: assert property (hit(NET_WR, NET_ADDR, `OFS_BW_LO) ||
      hit(NET_WR, NET_ADDR, `OFS_BW_HI) |=> TDIFF_CLR && SPEED_DIFF_CLR && (dev_r == 16'h0000))
      else $error("bandwidth write did not clear");
   a_dev_bounded: assert property (($signed(dev_r) <= $signed({1'b0, bw_r[14:0]} - 16'h007f)) &&
      ($signed(dev_r) >= -$signed({1'b0, bw_r[14:0]} - 16'h007f)))
      else $error("deviation outside bound");
   a_tdepth_clear: assert property (hit(NET_WR, NET_ADDR, `OFS_TD_DEPTH) |=> TDIFF_CLR)
      else $error("depth write did not clear difference");
   a_sdepth_filt: assert property (hit(NET_WR, NET_ADDR, `OFS_SP_DEPTH) |=> SPEED_FILT_CLR)
      else $error("speed depth write did not reset filter");
   a_host_loop_block: assert property (HOST_WR && !SYS_TIME_HOST_CTL && !NET_WR |=>
      $stable(BANDWIDTH) && !TDIFF_CLR && !SPEED_FILT_CLR)
      else $error("host changed loop register");
   a_owner_net_only: assert property (!NET_WR |=> $stable(SYNC_OWNER_HOST))
      else $error("ownership changed without network write");
   a_latch0_forced: assert property (SYS_TIME_HOST_CTL |=> LATCH0_OWNER_HOST)
      else $error("latch 0 not forced to host");
   a_irq_routing: assert property (LATCH_IRQ[1] && LATCH1_OWNER_HOST |->
      LATCH_IRQ_HOST[1] && !LATCH_IRQ_NET[1])
      else $error("latch 1 interrupt misrouted");
   a_act_owner_only: assert property (!own_r[`OWN_SYNC] && !NET_WR && !start_done |=>
      $stable(act_r))
      else $error("activation changed by non-owner");
   a_debug_pulse: assert property (dbg |=> (FIRST_SYNC_PULSE == $past(act_r[`ACT_EN0])) &&
      (SECOND_SYNC_PULSE == $past(act_r[`ACT_EN1])))
      else $error("debug pulse missing");
   a_auto_activate: assert property (start_done && act_r[`ACT_AUTO] |=> SYNC_UNIT_ACTIVE)
      else $error("auto activation failed");
endmodule

/* sim/sys_time_source.sv */
`timescale 1ns/1ps
// ****************************************
// far side system time, 5 ns a cycle
// ****************************************
module sys_time_source (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // time load
   input wire logic load,
   input wire logic [63:0] load_val,
   // time out
   output logic [63:0] sys_time
);
   logic [63:0] time_r;
   logic [63:0] time_nxt;
   // load or advance
   always_comb begin
      time_nxt = load ? load_val : time_r + 64'h5;
   end
   always_ff @(posedge clk) begin
      time_r <= rst_n ? time_nxt : 64'h0;
   end
   assign sys_time = time_r;
endmodule

/* sim/dc_time_loop_sync_out_control_test.sv */
`timescale 1ns/1ps
`include "dc_ctl_regs.svh"
module dc_time_loop_sync_out_control_test
   import dc_ctl_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] n_addr = '0, h_addr = '0;
   byte_t n_wdata = '0, h_wdata = '0, n_rdata, h_rdata;
   logic n_wr = 1'b0, n_rd = 1'b0, h_wr = 1'b0, h_rd = 1'b0, host_ctl = 1'b0, ld = 1'b0;
   logic n_rd_d = 1'b0, h_rd_d = 1'b0;
   logic [1:0] irq = '0, irq_n, irq_h, m;
   logic [15:0] dev_in = '0, b, lim, d, e;
   logic [63:0] sys_time, start_time, st, ld_val = '0;
   logic [14:0] bw;
   logic [3:0] tdd, spd;
   logic tclr, sclr, fclr, own_s, own0, own1, active, p0, p1;
   int errors = 0, tests_run = 0, cycles = 0;
   int pc[5] = '{default: 0};
   byte_t exp_q[$];
   always #2.5 sys_clk = ~sys_clk;
   sys_time_source u_time (.clk(sys_clk), .rst_n(rst_n), .load(ld), .load_val(ld_val), .sys_time(sys_time));
   dc_time_loop_sync_ctl u_dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
      .NET_ADDR(n_addr), .NET_WDATA(n_wdata), .NET_WR(n_wr), .NET_RD(n_rd), .NET_RDATA(n_rdata),
      .HOST_ADDR(h_addr), .HOST_WDATA(h_wdata), .HOST_WR(h_wr), .HOST_RD(h_rd), .HOST_RDATA(h_rdata),
      .SYS_TIME_HOST_CTL(host_ctl), .SYS_TIME(sys_time), .SPEED_DEV_IN(dev_in), .BANDWIDTH(bw),
      .TDIFF_DEPTH(tdd), .SPEED_DEPTH(spd), .TDIFF_CLR(tclr), .SPEED_DIFF_CLR(sclr),
      .SPEED_FILT_CLR(fclr), .SYNC_OWNER_HOST(own_s), .LATCH0_OWNER_HOST(own0),
      .LATCH1_OWNER_HOST(own1), .LATCH_IRQ(irq), .LATCH_IRQ_NET(irq_n), .LATCH_IRQ_HOST(irq_h),
      .SYNC_UNIT_ACTIVE(active), .START_TIME(start_time), .FIRST_SYNC_PULSE(p0),
      .SECOND_SYNC_PULSE(p1));
   // ****************************************
   // compare and close
   // ****************************************
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk8(input byte_t got, input byte_t exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ****************************************
   // bus tasks
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic wr(input bit host, input logic [11:0] a, input byte_t v);
      @(posedge sys_clk);
      n_addr <= a;
      h_addr <= a;
      n_wdata <= v;
      h_wdata <= v;
      n_wr <= !host;
      h_wr <= host;
      @(posedge sys_clk);
      n_wr <= 1'b0;
      h_wr <= 1'b0;
   endtask
   task automatic rd(input bit host, input logic [11:0] a, input byte_t v);
      @(posedge sys_clk);
      n_addr <= a;
      h_addr <= a;
      n_rd <= !host;
      h_rd <= host;
      exp_q.push_back(v);
      @(posedge sys_clk);
      n_rd <= 1'b0;
      h_rd <= 1'b0;
   endtask
   task automatic wr_start(input logic [63:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         wr(0, `OFS_START0 + 12'(i), v[8*i +: 8]);
      end
   endtask
   task automatic load_time(input logic [63:0] v);
      @(posedge sys_clk);
      ld_val <= v;
      ld <= 1'b1;
      @(posedge sys_clk);
      ld <= 1'b0;
   endtask
   // read data and pulse monitor, with timeout
   always @(posedge sys_clk) begin
      if (n_rd_d || h_rd_d) begin
         chk8(n_rd_d ? n_rdata : h_rdata, exp_q.pop_front());
      end
      n_rd_d = n_rd;
      h_rd_d = h_rd;
      pc[0] += int'(tclr === 1'b1);
      pc[1] += int'(sclr === 1'b1);
      pc[2] += int'(fclr === 1'b1);
      pc[3] += int'(p0 === 1'b1);
      pc[4] += int'(p1 === 1'b1);
      cycles++;
      if (cycles == 5000) begin
         errors++;
         close_out();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      void'($urandom(62));
      tick(6);
      rst_n <= 1'b1;
      rd(0, `OFS_BW_HI, 8'h10);
      rd(1, `OFS_SYNC_ACT, 8'h00);
      rd(0, 12'h900, 8'h00);
      // bandwidth, deviation clamp and clears
      for (int i = 0; i < 3; i++) begin
         b = 16'h0080 + 16'($urandom_range(32'h3f7f));
         lim = b - 16'h007f;
         d = (i == 0) ? lim - 16'($urandom_range(32'(lim) * 2)) : (i == 1 ? 16'h7fff : 16'h8000);
         e = (i == 0) ? d : (i == 1 ? lim : -lim);
         pc = '{default: 0};
         dev_in <= d;
         wr(0, `OFS_BW_LO, b[7:0]);
         wr(0, `OFS_BW_HI, b[15:8]);
         tick(3);
         chk(bw, b[14:0]);
         chk({pc[0], pc[1]}, {32'd2, 32'd2});
         rd(0, `OFS_DEV_LO, e[7:0]);
         rd(1, `OFS_DEV_HI, e[15:8]);
      end
      // filter depths
      pc = '{default: 0};
      d = 16'($urandom_range(15));
      wr(0, `OFS_TD_DEPTH, {4'h0, d[3:0]});
      wr(0, `OFS_SP_DEPTH, {4'h0, ~d[3:0]});
      tick(2);
      chk({tdd, spd}, {d[3:0], ~d[3:0]});
      chk({pc[0], pc[2]}, {32'd1, 32'd1});
      // host loop writes refused, then allowed
      wr(1, `OFS_TD_DEPTH, 8'h0f);
      wr(1, `OFS_BW_HI, 8'h01);
      tick(2);
      chk({tdd, pc[0]}, {d[3:0], 32'd1});
      host_ctl <= 1'b1;
      wr(1, `OFS_TD_DEPTH, 8'h0f);
      tick(2);
      chk({tdd, own0}, 5'h1f);
      host_ctl <= 1'b0;
      // ownership and latch interrupt routing
      wr(1, `OFS_CYC_OWN, 8'h31);
      tick(2);
      chk(own_s, 1'b0);
      for (int k = 0; k < 4; k++) begin
         m = 2'(k);
         irq <= 2'($urandom);
         wr(0, `OFS_CYC_OWN, {2'b00, m, 4'h1});
         tick(2);
         chk({own_s, own1, own0}, {1'b1, m});
         chk({irq_h, irq_n}, {irq & m, irq & ~m});
      end
      rd(0, `OFS_CYC_OWN, 8'h31);
      // activation by owner, debug pulse
      wr(0, `OFS_SYNC_ACT, 8'h07);
      tick(2);
      chk(active, 1'b0);
      pc = '{default: 0};
      wr(1, `OFS_SYNC_ACT, 8'h06);
      wr(1, `OFS_SYNC_ACT, 8'h86);
      wr(1, `OFS_SYNC_ACT, 8'h02);
      wr(1, `OFS_SYNC_ACT, 8'h82);
      wr(0, `OFS_SYNC_ACT, 8'h86);
      tick(3);
      chk({pc[3], pc[4]}, {32'd2, 32'd1});
      rd(0, `OFS_SYNC_ACT, 8'h02);
      wr(1, `OFS_SYNC_ACT, 8'h01);
      tick(1);
      chk(active, 1'b1);
      wr(1, `OFS_SYNC_ACT, 8'h00);
      wr(0, `OFS_CYC_OWN, 8'h00);
      // auto activation, wait for start time
      load_time(64'h0000_0001_0000_0000);
      wr(0, `OFS_SYNC_ACT, 8'h0a);
      st = sys_time + 64'd300;
      wr_start(st, 8);
      wr(0, `OFS_START0, 8'hff);
      tick(1);
      chk({active, start_time}, {1'b1, st});
      pc = '{default: 0};
      tick(15);
      chk(pc[3], 0);
      tick(60);
      chk(pc[3], 1);
      // 32-bit start time extension
      wr(0, `OFS_SYNC_ACT, 8'h00);
      tick(1);
      chk(active, 1'b0);
      load_time(64'h0000_0005_ffff_ff00);
      wr(0, `OFS_SYNC_ACT, 8'h1a);
      wr_start(64'h0000_0000_0000_0100, 4);
      tick(1);
      chk({active, start_time}, {1'b1, 64'h0000_0006_0000_0100});
      // plausibility window select
      for (int w = 0; w < 2; w++) begin
         wr(0, `OFS_SYNC_ACT, 8'h00);
         load_time(64'h0000_0010_0000_0000);
         wr(0, `OFS_SYNC_ACT, w ? 8'h6a : 8'h2a);
         pc = '{default: 0};
         wr_start(sys_time + 64'h0000_0001_0000_0000, 8);
         tick(4);
         chk(pc[3], w);
      end
      close_out();
   end
endmodule
